// File: brake_seq_map.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef BRAKE_SEQ_MAP_SVH
`define BRAKE_SEQ_MAP_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define BSQ_CLK_RATE_MHZ     25
`define BSQ_TICK_TIME_US     10000
`define BSQ_TICK_CYCLES      (`BSQ_TICK_TIME_US * `BSQ_CLK_RATE_MHZ)

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define BSQ_OFS_CTRL         8'h00
`define BSQ_OFS_AB_DELAY     8'h04
`define BSQ_OFS_PICK_DELAY   8'h08
`define BSQ_OFS_DROP_DELAY   8'h0C
`define BSQ_OFS_HOLD_TIME    8'h10
`define BSQ_OFS_START_LEVEL  8'h14
`define BSQ_OFS_STOP_LEVEL   8'h18
`define BSQ_OFS_ONSET_FREQ   8'h1C
`define BSQ_OFS_START_TIME   8'h20
`define BSQ_OFS_STOP_TIME    8'h24
`define BSQ_OFS_ZERO_THR     8'h28
`define BSQ_OFS_STATUS       8'h2C

// ----------------------------------------------------------------------
// Control and status bit positions
// ----------------------------------------------------------------------
`define BSQ_CTRL_RAMP        0
`define BSQ_CTRL_EXTBRK      1
`define BSQ_CTRL_HOLDSUP     2
`define BSQ_CTRL_FLTCLR      3
`define BSQ_ST_AUTOBRAKE     0
`define BSQ_ST_PICK          1
`define BSQ_ST_HOLDFLT       2
`define BSQ_ST_INJ           3
`define BSQ_ST_SPDREL        4
`define BSQ_ST_STATE_LSB     8

// ----------------------------------------------------------------------
// Reset values (times in 0.01 s, levels in 0.1 %, frequency in 0.1 Hz)
// ----------------------------------------------------------------------
`define BSQ_RST_RAMP         1'h1
`define BSQ_RST_EXTBRK       1'h1
`define BSQ_RST_HOLDSUP      1'h0
`define BSQ_RST_AB_DELAY     10'h000
`define BSQ_RST_PICK_DELAY   10'h032
`define BSQ_RST_DROP_DELAY   10'h032
`define BSQ_RST_HOLD_TIME    10'h014
`define BSQ_RST_START_TIME   10'h064
`define BSQ_RST_STOP_TIME    10'h064
`define BSQ_RST_START_LEVEL  11'h320
`define BSQ_RST_STOP_LEVEL   11'h1F4
`define BSQ_RST_ONSET_FREQ   7'h05
`define BSQ_RST_ZERO_THR     8'h00

// ----------------------------------------------------------------------
// Upper limits of the settings
// ----------------------------------------------------------------------
`define BSQ_MAX_AB_DELAY     16'h03E7
`define BSQ_MAX_TIME_5S      16'h01F4
`define BSQ_MAX_LEVEL        16'h05DC
`define BSQ_MAX_ONSET        16'h0064
`define BSQ_MAX_ZERO_THR     16'h00C8

`endif

// File: brake_seq_pkg.sv
// Types shared by the brake and DC injection sequencer.
package brake_seq_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_RUN   = 3'b010,
        ST_DECEL = 3'b011,
        ST_STOP  = 3'b100
    } seq_state_t;

    typedef struct packed {
        logic        rampStop;
        logic        extBrake;
        logic        holdSupEn;
        logic [9:0]  autobrakeReleaseDelay;
        logic [9:0]  pickDelay;
        logic [9:0]  dropDelay;
        logic [9:0]  holdTime;
        logic [9:0]  startInjectionTime;
        logic [9:0]  stopInjectionTime;
        logic [10:0] startInjectionLevel;
        logic [10:0] stopInjectionLevel;
        logic [6:0]  injectionOnsetFrequency;
        logic [7:0]  zeroSpeedThreshold;
    } cfg_t;

    typedef struct packed {
        seq_state_t  state;
        cfg_t        cfg;
        logic [9:0]  seqCnt;
        logic [9:0]  zeroCnt;
        logic [9:0]  holdCnt;
        logic        autoBrake;
        logic        brakePick;
        logic        holdFault;
        logic        injActive;
        logic [10:0] injLevel;
        logic        spdRel;
        logic [31:0] rdata;
    } seq_regs_t;

endpackage

// File: tick_divider.sv
// Divides the system clock into a one-cycle tick enable.
module tick_divider #(
    parameter int unsigned DIV = 250000
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic resetn,
    // Tick enable
    output logic      tick
);

    localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } div_t;

    div_t r;
    div_t n;

    always_comb begin
        n = r;
        n.tick = 1'b0;
        if (r.cnt == W'(DIV - 1)) begin
            n.cnt  = '0;
            n.tick = 1'b1;
        end else begin
            n.cnt = r.cnt + W'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign tick = r.tick;

endmodule

// File: brake_dc_injection_sequencer.sv
// Brake and DC injection sequencer with APB configuration registers.
`include "brake_seq_map.svh"

module brake_dc_injection_sequencer #(
    parameter int unsigned TICK_CYCLES = `BSQ_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Drive state
    input  wire logic        runRequest,
    input  wire logic [15:0] speedPct,
    input  wire logic [7:0]  outFreq,
    input  wire logic        holdFeedback,
    // Brake and injection outputs
    output logic             autoBrakeOut,
    output logic             brakePickOut,
    output logic             hold_feedback_fault,
    output logic             injectionActive,
    output logic [10:0]      injectionLevel,
    output logic             speedRefRelease
);

    // ------------------------------------------------------------------
    // Reset image
    // ------------------------------------------------------------------
    localparam brake_seq_pkg::cfg_t CFG_RST = '{
        rampStop:                `BSQ_RST_RAMP,
        extBrake:                `BSQ_RST_EXTBRK,
        holdSupEn:               `BSQ_RST_HOLDSUP,
        autobrakeReleaseDelay:   `BSQ_RST_AB_DELAY,
        pickDelay:               `BSQ_RST_PICK_DELAY,
        dropDelay:               `BSQ_RST_DROP_DELAY,
        holdTime:                `BSQ_RST_HOLD_TIME,
        startInjectionTime:      `BSQ_RST_START_TIME,
        stopInjectionTime:       `BSQ_RST_STOP_TIME,
        startInjectionLevel:     `BSQ_RST_START_LEVEL,
        stopInjectionLevel:      `BSQ_RST_STOP_LEVEL,
        injectionOnsetFrequency: `BSQ_RST_ONSET_FREQ,
        zeroSpeedThreshold:      `BSQ_RST_ZERO_THR
    };

    localparam brake_seq_pkg::seq_regs_t REGS_RST = '{
        state:     brake_seq_pkg::ST_IDLE,
        cfg:       CFG_RST,
        seqCnt:    10'h000,
        zeroCnt:   10'h000,
        holdCnt:   10'h000,
        autoBrake: 1'h0,
        brakePick: 1'h0,
        holdFault: 1'h0,
        injActive: 1'h0,
        injLevel:  11'h000,
        spdRel:    1'h0,
        rdata:     32'h0000_0000
    };

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Settings above their limit saturate at the limit.
    function automatic logic [15:0] clampTo(input logic [15:0] v,
                                            input logic [15:0] lim);
        clampTo = (v > lim) ? lim : v;
    endfunction

    function automatic logic [9:0] satInc(input logic [9:0] v);
        satInc = (v == 10'h3FF) ? v : v + 10'h001;
    endfunction

    brake_seq_pkg::seq_regs_t r;
    brake_seq_pkg::seq_regs_t n;

    logic        tick;
    logic        wrStrobe;
    logic        setupRead;
    logic        mapped;
    logic        fltClr;
    logic        atZero;
    logic        atOnset;
    logic        holdMismatch;
    logic [15:0] wdLow;
    logic [31:0] readVal;

    tick_divider #(
        .DIV(TICK_CYCLES)
    ) u_tick (
        .clk_sys(clk_sys),
        .resetn (resetn),
        .tick   (tick)
    );

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    assign wdLow     = pwdata[15:0];
    assign wrStrobe  = psel & penable & pwrite & mapped;
    assign setupRead = psel & ~penable & ~pwrite;
    assign pready    = 1'b1;
    assign pslverr   = psel & penable & ~mapped;
    assign fltClr    = wrStrobe & (paddr == `BSQ_OFS_CTRL)
                       & pwdata[`BSQ_CTRL_FLTCLR];

    always_comb begin
        mapped  = 1'b1;
        readVal = 32'h0000_0000;
        case (paddr)
            `BSQ_OFS_CTRL: begin
                readVal[`BSQ_CTRL_RAMP]    = r.cfg.rampStop;
                readVal[`BSQ_CTRL_EXTBRK]  = r.cfg.extBrake;
                readVal[`BSQ_CTRL_HOLDSUP] = r.cfg.holdSupEn;
            end
            `BSQ_OFS_AB_DELAY:    readVal[9:0] = r.cfg.autobrakeReleaseDelay;
            `BSQ_OFS_PICK_DELAY:  readVal[9:0] = r.cfg.pickDelay;
            `BSQ_OFS_DROP_DELAY:  readVal[9:0] = r.cfg.dropDelay;
            `BSQ_OFS_HOLD_TIME:   readVal[9:0] = r.cfg.holdTime;
            `BSQ_OFS_START_LEVEL: readVal[10:0] = r.cfg.startInjectionLevel;
            `BSQ_OFS_STOP_LEVEL:  readVal[10:0] = r.cfg.stopInjectionLevel;
            `BSQ_OFS_ONSET_FREQ:
                readVal[6:0] = r.cfg.injectionOnsetFrequency;
            `BSQ_OFS_START_TIME:  readVal[9:0] = r.cfg.startInjectionTime;
            `BSQ_OFS_STOP_TIME:   readVal[9:0] = r.cfg.stopInjectionTime;
            `BSQ_OFS_ZERO_THR:    readVal[7:0] = r.cfg.zeroSpeedThreshold;
            `BSQ_OFS_STATUS: begin
                readVal[`BSQ_ST_AUTOBRAKE] = r.autoBrake;
                readVal[`BSQ_ST_PICK]      = r.brakePick;
                readVal[`BSQ_ST_HOLDFLT]   = r.holdFault;
                readVal[`BSQ_ST_INJ]       = r.injActive;
                readVal[`BSQ_ST_SPDREL]    = r.spdRel;
                readVal[`BSQ_ST_STATE_LSB +: 3] = r.state;
            end
            default: mapped = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Speed and feedback conditions
    // ------------------------------------------------------------------
    // zero speed test
    assign atZero = speedPct <= {8'h00, r.cfg.zeroSpeedThreshold};
    assign atOnset = outFreq <= {1'b0, r.cfg.injectionOnsetFrequency};
    assign holdMismatch = holdFeedback != r.brakePick;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        n = r;

        if (setupRead) begin
            n.rdata = readVal;
        end

        if (wrStrobe) begin
            case (paddr)
                `BSQ_OFS_CTRL: begin
                    n.cfg.rampStop  = pwdata[`BSQ_CTRL_RAMP];
                    n.cfg.extBrake  = pwdata[`BSQ_CTRL_EXTBRK];
                    n.cfg.holdSupEn = pwdata[`BSQ_CTRL_HOLDSUP];
                end
                `BSQ_OFS_AB_DELAY: n.cfg.autobrakeReleaseDelay =
                    10'(clampTo(wdLow, `BSQ_MAX_AB_DELAY));
                `BSQ_OFS_PICK_DELAY: n.cfg.pickDelay =
                    10'(clampTo(wdLow, `BSQ_MAX_TIME_5S));
                `BSQ_OFS_DROP_DELAY: n.cfg.dropDelay =
                    10'(clampTo(wdLow, `BSQ_MAX_TIME_5S));
                `BSQ_OFS_HOLD_TIME: n.cfg.holdTime =
                    10'(clampTo(wdLow, `BSQ_MAX_TIME_5S));
                `BSQ_OFS_START_LEVEL: n.cfg.startInjectionLevel =
                    11'(clampTo(wdLow, `BSQ_MAX_LEVEL));
                `BSQ_OFS_STOP_LEVEL: n.cfg.stopInjectionLevel =
                    11'(clampTo(wdLow, `BSQ_MAX_LEVEL));
                `BSQ_OFS_ONSET_FREQ: n.cfg.injectionOnsetFrequency =
                    7'(clampTo(wdLow, `BSQ_MAX_ONSET));
                `BSQ_OFS_START_TIME: n.cfg.startInjectionTime =
                    10'(clampTo(wdLow, `BSQ_MAX_TIME_5S));
                `BSQ_OFS_STOP_TIME: n.cfg.stopInjectionTime =
                    10'(clampTo(wdLow, `BSQ_MAX_TIME_5S));
                `BSQ_OFS_ZERO_THR: n.cfg.zeroSpeedThreshold =
                    8'(clampTo(wdLow, `BSQ_MAX_ZERO_THR));
                default: ;
            endcase
        end

        if (!atZero) begin
            n.zeroCnt   = 10'h000;
            n.autoBrake = 1'b1;
        end else begin
            if (tick) begin
                n.zeroCnt = satInc(r.zeroCnt);
            end
            if (r.zeroCnt >= r.cfg.autobrakeReleaseDelay) begin
                n.autoBrake = 1'b0;
            end
        end

        if (r.cfg.holdSupEn && holdMismatch) begin
            if (tick) begin
                n.holdCnt = satInc(r.holdCnt);
            end
        end else begin
            n.holdCnt = 10'h000;
        end
        // A new fault in the clearing cycle survives the clear.
        n.holdFault = (r.holdFault & ~fltClr)
                      | (r.cfg.holdSupEn & holdMismatch
                         & (r.holdCnt >= r.cfg.holdTime));

        if (tick) begin
            n.seqCnt = satInc(r.seqCnt);
        end

        n.injActive = 1'b0;
        n.injLevel  = 11'h000;
        n.spdRel    = 1'b0;

        case (r.state)
            brake_seq_pkg::ST_IDLE: begin
                n.brakePick = 1'b0;
                n.seqCnt    = 10'h000;
                if (runRequest) begin
                    n.state = brake_seq_pkg::ST_START;
                end
            end
            brake_seq_pkg::ST_START: begin
                n.injActive = 1'b1;
                n.injLevel  = r.cfg.startInjectionLevel;
                if (r.cfg.extBrake && r.seqCnt >= r.cfg.pickDelay) begin
                    n.brakePick = 1'b1;
                end
                if (!runRequest) begin
                    n.state     = brake_seq_pkg::ST_IDLE;
                    n.brakePick = 1'b0;
                    n.injActive = 1'b0;
                    n.injLevel  = 11'h000;
                end else if (r.seqCnt >= r.cfg.startInjectionTime
                             && (n.brakePick || !r.cfg.extBrake)) begin
                    n.state     = brake_seq_pkg::ST_RUN;
                    n.spdRel    = 1'b1;
                    n.injActive = 1'b0;
                    n.injLevel  = 11'h000;
                end
            end
            brake_seq_pkg::ST_RUN: begin
                n.spdRel = 1'b1;
                if (!runRequest) begin
                    if (r.cfg.rampStop) begin
                        n.state = brake_seq_pkg::ST_DECEL;
                    end else begin
                        n.state     = brake_seq_pkg::ST_IDLE;
                        n.spdRel    = 1'b0;
                        n.brakePick = 1'b0;
                    end
                end
            end
            brake_seq_pkg::ST_DECEL: begin
                n.spdRel = 1'b1;
                if (runRequest) begin
                    n.state = brake_seq_pkg::ST_RUN;
                end else if (atOnset) begin
                    n.state     = brake_seq_pkg::ST_STOP;
                    n.seqCnt    = 10'h000;
                    n.spdRel    = 1'b0;
                    n.injActive = 1'b1;
                    n.injLevel  = r.cfg.stopInjectionLevel;
                end
            end
            brake_seq_pkg::ST_STOP: begin
                if (r.seqCnt < r.cfg.stopInjectionTime) begin
                    n.injActive = 1'b1;
                    n.injLevel  = r.cfg.stopInjectionLevel;
                end
                if (!r.cfg.extBrake || r.seqCnt >= r.cfg.dropDelay) begin
                    n.brakePick = 1'b0;
                end
                if (!n.injActive && !n.brakePick) begin
                    n.state = brake_seq_pkg::ST_IDLE;
                end
            end
            default: begin
                n.state     = brake_seq_pkg::ST_IDLE;
                n.brakePick = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            r <= REGS_RST;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata              = r.rdata;
    assign autoBrakeOut        = r.autoBrake;
    assign brakePickOut        = r.brakePick;
    assign hold_feedback_fault = r.holdFault;
    assign injectionActive     = r.injActive;
    assign injectionLevel      = r.injLevel;
    assign speedRefRelease     = r.spdRel;

endmodule

// File: brake_seq_properties.sv
// Port-level checker for the brake and injection sequencer.
module brake_seq_properties #(
    parameter int unsigned TICK_CYCLES = 4
) (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        resetn,
    // Drive state
    input wire logic        runRequest,
    input wire logic [15:0] speedPct,
    input wire logic [7:0]  outFreq,
    input wire logic        holdFeedback,
    // Outputs
    input wire logic        autoBrakeOut,
    input wire logic        brakePickOut,
    input wire logic        hold_feedback_fault,
    input wire logic        injectionActive,
    input wire logic [10:0] injectionLevel,
    input wire logic        speedRefRelease
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    sequence s_idle;
        !runRequest && !injectionActive && !brakePickOut
            && !speedRefRelease;
    endsequence
    sequence s_runHeld;
        runRequest [*3];
    endsequence

    ab_fall_zero_a:
        assert property ($fell(autoBrakeOut) |-> $past(speedPct) <= 16'h00C8)
        else $error("auto-brake fell above zero speed");
    ab_rise_speed_a:
        assert property (speedPct > 16'h00C8 |=> autoBrakeOut)
        else $error("auto-brake low while moving");
    pick_under_inj_a:
        assert property ($rose(brakePickOut) |-> injectionActive)
        else $error("brake picked without start injection");
    pick_drop_a:
        assert property ($fell(brakePickOut) |-> !speedRefRelease)
        else $error("brake set with speed released");
    fault_cause_a:
        assert property ($rose(hold_feedback_fault)
            |-> $past(holdFeedback != brakePickOut))
        else $error("hold fault without mismatch");
    level_cap_a:
        assert property (injectionLevel <= 11'h5DC
            && (injectionActive || injectionLevel == 11'h000))
        else $error("injection level out of range");
    inj_excl_a:
        assert property (!(injectionActive && speedRefRelease))
        else $error("injection while speed released");
    release_cause_a:
        assert property ($rose(speedRefRelease)
            |-> $past(injectionActive && runRequest))
        else $error("release without start injection");
    onset_a:
        assert property ($fell(speedRefRelease) && injectionActive
            |-> $past(outFreq) <= 8'h64)
        else $error("stop injection above onset limit");
    start_inj_a:
        assert property (s_idle ##1 s_runHeld
            |-> injectionActive || speedRefRelease)
        else $error("run did not start injection");
endmodule

bind brake_dc_injection_sequencer brake_seq_properties #(
    .TICK_CYCLES(TICK_CYCLES)
) i_brake_seq_properties (
    .clk_sys, .resetn, .runRequest, .speedPct, .outFreq, .holdFeedback,
    .autoBrakeOut, .brakePickOut, .hold_feedback_fault, .injectionActive,
    .injectionLevel, .speedRefRelease
);

// File: brake_plant.sv
// Model of the brake, its hold contact and the motor shaft.
module brake_plant (
    // Clock and reset
    input  wire logic   clk_sys,
    input  wire logic   resetn,
    // Drive commands
    input  wire logic   brakePickOut,
    input  wire logic   runRequest,
    input  wire logic   speedRefRelease,
    // Test controls
    input  wire logic   slowContact,
    input  wire logic   stuckContact,
    // Feedback
    output logic        holdFeedback,
    output logic [15:0] speedPct,
    output logic [7:0]  outFreq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0]  contact_q = '0;
    logic [15:0] speed_q = '0;

    // The shaft ramps 0.5 % a cycle; a stuck contact reads inverted.
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            contact_q <= '0;
            speed_q <= '0;
        end else begin
            contact_q <= {contact_q[4:0], brakePickOut};
            if (speedRefRelease && runRequest) begin
                if (speed_q < 16'h1388)
                    speed_q <= speed_q + 16'h0032;
            end else if (speed_q != 16'h0000) begin
                speed_q <= speed_q - 16'h0032;
            end
        end
    end
    assign holdFeedback = stuckContact
        ^ (slowContact ? contact_q[5] : contact_q[0]);
    assign speedPct = speed_q;
    assign outFreq = 8'(speed_q / 16'h0032);
endmodule

// File: test_brake_dc_injection_sequencer.sv
// Self-checking bench for the brake and injection sequencer.
module test_brake_dc_injection_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 0, resetn = 0;
    logic        psel = 0, penable = 0, pwrite = 0, se;
    logic [7:0]  paddr = '0, outFreq;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, holdFeedback, autoBrakeOut, fault;
    logic        runRequest = 0, slowContact = 0, stuckContact = 0;
    logic        brakePickOut, injectionActive, speedRefRelease;
    logic [10:0] injectionLevel;
    logic [15:0] speedPct;
    int          n_errors = 0, n_tests = 0, n;
    time         t0, t1;
    logic [7:0]  ra [12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
                             8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C};
    logic [31:0] rv [12] = '{32'h3, 32'h0, 32'h32, 32'h32, 32'h14, 32'h320,
                             32'h1F4, 32'h5, 32'h64, 32'h64, 32'h0, 32'h0};
    logic [31:0] sv [12] = '{32'h7, 32'h3E7, 32'h1F4, 32'h1F4, 32'h1F4,
        32'h5DC, 32'h5DC, 32'h64, 32'h1F4, 32'h1F4, 32'hC8, 32'h0};
    logic [31:0] cv [12] = '{32'h7, 32'h6, 32'h2, 32'h2, 32'h3, 32'h320,
                             32'h1F4, 32'h5, 32'h4, 32'h4, 32'h0, 32'h0};

    brake_dc_injection_sequencer #(
        .TICK_CYCLES(4)
    ) i_brake_dc_injection_sequencer (
        .clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .runRequest, .speedPct, .outFreq,
        .holdFeedback, .autoBrakeOut, .brakePickOut,
        .hold_feedback_fault(fault), .injectionActive, .injectionLevel,
        .speedRefRelease);
    brake_plant i_brake_plant (
        .clk_sys, .resetn, .brakePickOut, .runRequest, .speedRefRelease,
        .slowContact, .stuckContact, .holdFeedback, .speedPct, .outFreq);

    initial begin
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic chk(logic [31:0] got, logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Cycle count must fit t ticks of 4 cycles, tick phase being free.
    task automatic rng(int c, int t);
        chk(c >= 4 * t - 4 && c <= 4 * t + 8, 1);
    endtask
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    function automatic logic sig(int k);
        case (k)
            0: return brakePickOut;
            1: return speedRefRelease;
            2: return injectionActive;
            3: return autoBrakeOut;
            4: return fault;
            default: return speedPct == 16'h0000;
        endcase
    endfunction
    task automatic wt(int k, logic v, int t);
        n = 0;
        while (sig(k) !== v && n < 3000) begin
            @(posedge clk_sys);
            n++;
        end
        if (t >= 0)
            rng(n, t);
        else
            chk(sig(k), v);
    endtask
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------
    // Tests
    // ------
    initial begin
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        apb(1, 8'h2C, 32'hFFFF);
        foreach (ra[i]) begin
            apb(0, ra[i], 0);
            chk(rd, rv[i]);
            apb(1, ra[i], 32'hFFFF);
            apb(0, ra[i], 0);
            chk(rd, sv[i]);
        end
        apb(1, 8'h30, 32'h1);
        chk(se, 1);
        apb(0, 8'h30, 0);
        chk(rd, 0);
        foreach (ra[i]) begin
            apb(1, ra[i], cv[i]);
        end
        apb(1, 8'h08, 32'h2);
        $display("test 1 done");
        slowContact <= 1'b1;
        runRequest <= 1'b1;
        wt(0, 1, 2);
        chk(injectionLevel, 11'h320);
        wt(1, 1, 2);
        repeat (50) @(posedge clk_sys);
        chk(autoBrakeOut, 1);
        runRequest <= 1'b0;
        wt(2, 1, -1);
        t1 = $time;
        chk(injectionLevel, 11'h1F4);
        chk(outFreq <= 8'h05, 1);
        wt(5, 1, -1);
        t0 = $time;
        wt(0, 0, -1);
        rng(int'(($time - t1) / 40), 2);
        wt(2, 0, 2);
        wt(3, 0, -1);
        rng(int'(($time - t0) / 40), 6);
        chk(fault, 0);
        $display("test 2 done");
        stuckContact <= 1'b1;
        wt(4, 1, 3);
        apb(1, 8'h00, 32'hF);
        chk(fault, 1);
        stuckContact <= 1'b0;
        @(posedge clk_sys);
        apb(1, 8'h00, 32'hF);
        apb(0, 8'h2C, 0);
        chk(rd[2], 0);
        $display("test 3 done");
        apb(1, 8'h00, 32'h0);
        runRequest <= 1'b1;
        wt(1, 1, 4);
        chk(brakePickOut, 0);
        runRequest <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk(speedRefRelease, 0);
        chk(injectionActive, 0);
        $display("test 4 done");
        final_report;
    end

    initial begin
        #800000;
        n_errors++;
        final_report;
    end
endmodule
